// File: dv/ahss_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural converter serial port, external clocking mode
module ahss_dev_model (
  input wire logic serial_clk,
  input wire logic receive_frame_n,
  input wire logic transmit_frame_n,
  input wire logic register_select,
  input wire logic cal_pick,
  input wire logic load,
  input wire logic [23:0] load_word,
  input wire logic host_data,
  output logic dev_data,
  output logic dev_oe,
  output logic result_ready_n
);
  logic [23:0] ctrl_word = 24'h000000; // control register
  logic [23:0] cal_word = 24'h000000; // calibration register
  logic [23:0] out_word = 24'h000000; // output data register
  logic [23:0] rd_word = 24'h000000; // word being shifted out
  logic [23:0] wr_sr = 24'h000000; // incoming write bits
  logic [4:0] rd_cnt = 5'h00;
  logic [4:0] wr_cnt = 5'h00;
  logic rd_out = 1'b0; // frame reads the output register
  logic rd_live = 1'b0; // frame really moves data
  initial result_ready_n = 1'b1;
  // a fresh result pulls ready low
  always @(posedge load)
  begin
    out_word = load_word;
    result_ready_n = 1'b0;
  end
  // select settles in the same step as the strobe, so look a little later
  always @(negedge receive_frame_n)
  begin
    #1;
    rd_cnt = 5'h00;
    rd_out = register_select && !cal_pick;
    rd_live = !(rd_out && result_ready_n);
    rd_word = !register_select ? ctrl_word : (cal_pick ? cal_word : out_word);
  end
  // each falling clock edge moves to the next bit; on an output register read the last one raises ready
  always @(negedge serial_clk)
  begin
    if (!receive_frame_n && rd_cnt < 5'h18)
    begin
      rd_cnt = rd_cnt + 5'h01;
      if (rd_cnt == 5'h18 && rd_out && rd_live)
        result_ready_n = 1'b1;
    end
  end
  assign dev_oe = !receive_frame_n && rd_live && rd_cnt < 5'h18;
  // released line shows the inverse of the last bit, never a stale copy
  assign dev_data = dev_oe ? rd_word[5'h17 - rd_cnt] : ~rd_word[0];
  always @(negedge transmit_frame_n)
  begin
    wr_cnt = 5'h00;
  end
  // bits taken on the rising clock, first bit is the msb; select read at commit
  always @(posedge serial_clk)
  begin
    if (!transmit_frame_n && wr_cnt < 5'h18)
    begin
      wr_sr = {wr_sr[22:0], host_data};
      wr_cnt = wr_cnt + 5'h01;
      if (wr_cnt == 5'h18 && register_select)
        cal_word = wr_sr;
      else if (wr_cnt == 5'h18)
        ctrl_word = wr_sr;
    end
  end
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ahss_pkg::*;
  typedef struct packed {
    logic w;
    ahss_target_t t;
    logic l;
    logic [23:0] ldw; // result to load first, zero for none
    logic [23:0] d;
    logic e;
    logic [23:0] q;
  } ahss_row_t;
  // ordinary cases: command, then the expected answer
  localparam ahss_row_t ROWS [10] = '{
    '{1'b1, TGT_CTRL, 1'b0, 24'h000000, 24'hA5C3F0, 1'b0, 24'h000000},
    '{1'b0, TGT_CTRL, 1'b0, 24'h000000, 24'h000000, 1'b0, 24'hA5C3F0},
    '{1'b1, TGT_CAL, 1'b0, 24'h000000, 24'h13579B, 1'b0, 24'h000000},
    '{1'b0, TGT_CAL, 1'b0, 24'h000000, 24'h000000, 1'b0, 24'h13579B},
    '{1'b0, TGT_DATA, 1'b0, 24'hC0FFEE, 24'h000000, 1'b0, 24'hC0FFEE},
    '{1'b1, TGT_DATA, 1'b0, 24'h000000, 24'h111111, 1'b1, 24'h000000},
    '{1'b1, TGT_CTRL, 1'b1, 24'h000000, 24'h010203, 1'b0, 24'h000000},
    '{1'b0, TGT_CTRL, 1'b0, 24'h000000, 24'h000000, 1'b0, 24'h8040C0},
    '{1'b0, TGT_CTRL, 1'b1, 24'h000000, 24'h000000, 1'b0, 24'h010203},
    '{1'b0, TGT_DATA, 1'b1, 24'h8001FE, 24'h000000, 1'b0, 24'h01807F}};
  logic mclk = 1'b0;
  logic rst_n = 1'b1;
  logic tied = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic lsb = 1'b0;
  ahss_target_t tgt = TGT_DATA;
  logic [23:0] wdata = 24'h000000;
  logic [23:0] load_word = 24'h000000;
  logic cal_pick = 1'b0;
  logic load = 1'b0;
  logic e;
  logic [23:0] q;
  wire logic cmd_ready, rsp_valid, rsp_error, result_event, serial_clk;
  wire logic rx_n, tx_n, sel, sd_o, sd_oe, dev_data, dev_oe, ready_n, sd_wire, dev_sel;
  wire logic [23:0] rsp_data;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int pulses = 0;
  int events = 0;
  int rx_falls = 0;
  always #20 mclk = ~mclk;
  // shared data wire: host when enabled, else the converter
  assign sd_wire = sd_oe ? sd_o : dev_data;
  // tied board: transmit strobe doubles as register select
  assign dev_sel = tied ? tx_n : sel;
  ahss_host DUT (.mclk(mclk), .rst_n(rst_n), .tied_select(tied), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_target(tgt), .cmd_lsb_first(lsb),
    .cmd_wdata(wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_data(rsp_data),
    .result_event(result_event), .serial_clk(serial_clk), .receive_frame_n(rx_n),
    .transmit_frame_n(tx_n), .register_select(sel), .serial_data_i(sd_wire),
    .serial_data_o(sd_o), .serial_data_oe(sd_oe), .result_ready_n(ready_n));
  ahss_dev_model partner (.serial_clk(serial_clk), .receive_frame_n(rx_n),
    .transmit_frame_n(tx_n), .register_select(dev_sel), .cal_pick(cal_pick), .load(load),
    .load_word(load_word), .host_data(sd_wire), .dev_data(dev_data), .dev_oe(dev_oe),
    .result_ready_n(ready_n));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // pin activity monitors
  always @(posedge serial_clk) pulses++;
  always @(negedge rx_n) rx_falls++;
  // hang guard and result event count
  always @(posedge mclk)
  begin
    cycles++;
    if (result_event === 1'b1)
      events++;
    if (cycles == 10000)
    begin
      num_errors++;
      test_done();
    end
  end
  // the two strobes are never low together
  always @(negedge mclk) chk(24'(rx_n | tx_n), 24'h000001);
  task automatic push(input logic [23:0] w);
    @(posedge mclk);
    load_word <= w;
    load <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
  endtask
  // one command: offer, hand over at the next edge, wait for the answer
  task automatic run(input logic w, input ahss_target_t t, input logic l,
    input logic [23:0] d, output logic er, output logic [23:0] rd);
    @(posedge mclk);
    cmd_write <= w;
    tgt <= t;
    lsb <= l;
    wdata <= d;
    cal_pick <= (t == TGT_CAL);
    cmd_valid <= 1'b1;
    pulses = 0;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    @(negedge mclk);
    while (rsp_valid !== 1'b1) @(negedge mclk);
    er = rsp_error;
    rd = rsp_data;
  endtask
  task automatic idle_chk;
    chk({20'h00000, serial_clk, rx_n, tx_n, sel}, 24'h000007);
  endtask
  initial
  begin
    // start high so that this drop is a real edge for the asynchronous reset
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    @(negedge mclk) idle_chk();
    chk(24'(cmd_ready), 24'h000001);
    $display("reset test done");
    for (int i = 0; i < 10; i++)
    begin
      if (ROWS[i].ldw != 24'h000000)
        push(ROWS[i].ldw);
      run(ROWS[i].w, ROWS[i].t, ROWS[i].l, ROWS[i].d, e, q);
      chk(24'(e), 24'(ROWS[i].e));
      if (!ROWS[i].e)
        chk(q, ROWS[i].q);
      chk(24'(pulses), ROWS[i].e ? 24'h000000 : 24'h000018);
      @(negedge mclk) idle_chk();
      chk(24'(ready_n), 24'h000001);
      $display("row %0d test done", i);
    end
    // data read with no result yet must hold off the frame
    rx_falls = 0;
    fork
      run(1'b0, TGT_DATA, 1'b0, 24'h000000, e, q);
      begin
        repeat (100) @(posedge mclk);
        chk(24'(rx_falls), 24'h000000);
        push(24'h3C3C3C);
      end
    join
    chk(q, 24'h3C3C3C);
    chk(24'(rx_falls), 24'h000001);
    $display("ready wait test done");
    // tied wiring: writes land in control, reads see data or calibration
    @(posedge mclk) tied <= 1'b1;
    run(1'b1, TGT_CTRL, 1'b0, 24'h5A5A5A, e, q);
    chk(24'(e), 24'h000000);
    run(1'b0, TGT_CTRL, 1'b0, 24'h000000, e, q);
    chk(24'(e), 24'h000001);
    run(1'b1, TGT_CAL, 1'b0, 24'hFFFFFF, e, q);
    chk(24'(e), 24'h000001);
    run(1'b0, TGT_CAL, 1'b0, 24'h000000, e, q);
    chk(q, 24'h13579B);
    push(24'h600DAB);
    run(1'b0, TGT_DATA, 1'b0, 24'h000000, e, q);
    chk(q, 24'h600DAB);
    @(posedge mclk) tied <= 1'b0;
    $display("tied test done");
    // reset in mid write: pins idle at once, control word untouched
    @(posedge mclk);
    cmd_write <= 1'b1;
    tgt <= TGT_CTRL;
    wdata <= 24'hFFFFFF;
    cmd_valid <= 1'b1;
    @(posedge mclk) cmd_valid <= 1'b0;
    repeat (60) @(posedge mclk);
    rst_n <= 1'b0;
    @(negedge mclk) idle_chk();
    chk(24'(sd_oe), 24'h000000);
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    run(1'b0, TGT_CTRL, 1'b0, 24'h000000, e, q);
    chk(q, 24'h5A5A5A);
    chk(24'(events), 24'h000004);
    $display("mid reset test done");
    test_done();
  end
endmodule
`default_nettype wire

// File: logic/ahss_half_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ahss_half_timer
  import ahss_pkg::*;
#(
  parameter int HALF = HALF_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  // counter width covers the half period
  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt_reg;
  // tick marks the end of each half serial clock period
  assign tick = run && (cnt_reg == LAST);
  // held at zero while stopped so every phase starts full length
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else if (!run || tick)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + CW'(1);
  end
endmodule
`default_nettype wire

// File: logic/ahss_host.sv
// Functional notes
// - tied wiring: every write hits control
// - tied wiring: every read hits data/calibration
// - tied wiring: control read is refused
// - transmit strobe may be inverted receive strobe
// - never derive receive strobe from transmit
// - new result seen by polling or event
// - result read as three bytes, one frame
// - ready line ignored for register reads
// - control read: select low with receive strobe
// - write data sent most significant bit first
// - LSB-first option reverses bits per byte
// - register write is one 24-bit operation
// - sample ready low before each data byte
// - all strobes and select idle high
// - three bytes stored, then receive strobe high
// - every register write carries 24 bits
`timescale 1ns/1ps
`default_nettype none
module ahss_host
  import ahss_pkg::*;
#(
  parameter int HALF = HALF_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tied_select,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire ahss_target_t cmd_target,
  input wire logic cmd_lsb_first,
  input wire logic [23:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [23:0] rsp_data,
  output logic result_event,
  output logic serial_clk,
  output logic receive_frame_n,
  output logic transmit_frame_n,
  output logic register_select,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe,
  input wire logic result_ready_n
);
  // whole sequencer state in one record
  typedef struct packed {
    ahss_state_t st;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [23:0] shift;
    logic wr;
    ahss_target_t tgt;
    logic lsb;
    logic sclk;
    logic rfs_n;
    logic tfs_n;
    logic rsel;
    logic sdo;
    logic oe;
    logic rsp_valid;
    logic rsp_err;
    logic [23:0] rsp_data;
    logic rdy_prev;
    logic evt;
  } ahss_host_state_t;

  ahss_host_state_t s_reg;
  ahss_host_state_t s_next;
  logic [1:0] rst_pipe; // reset release pipeline
  logic rst_sync_n; // released reset used everywhere
  logic [1:0] pin_sync; // synced {ready, data in}
  logic rdy_s; // synced ready line, low means fresh result
  logic sdi_s; // synced serial data in
  logic tick; // end of half serial period

  // reset asserts at once, releases after two clean edges
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_sync_n = rst_pipe[1];

  // pins from the device cross into mclk through two flops
  ahss_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .async_in({result_ready_n, serial_data_i}),
    .sync_out(pin_sync)
  );
  assign rdy_s = pin_sync[1];
  assign sdi_s = pin_sync[0];

  // half period timer paces the serial clock from mclk
  ahss_half_timer #(.HALF(HALF)) u_timer (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .run((s_reg.st == ST_LOW) || (s_reg.st == ST_HIGH) || (s_reg.st == ST_CLOSE)),
    .tick(tick)
  );

  // requests the host itself will not issue
  function automatic logic refused(input logic wr, input ahss_target_t t, input logic tied);
    // output register is read only; tied wiring blocks control reads and cal writes
    return (wr && t == TGT_DATA) || (tied && !wr && t == TGT_CTRL)
      || (tied && wr && t == TGT_CAL);
  endfunction

  // select level for a transfer
  function automatic logic select_level(input logic wr, input ahss_target_t t,
    input logic tied);
    if (tied)
      return !wr;
    return t != TGT_CTRL;
  endfunction

  // handshake is combinational from the idle state
  assign cmd_ready = (s_reg.st == ST_IDLE);

  // next state of the sequencer
  always_comb
  begin
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.rdy_prev = rdy_s;
    // falling ready line is the interrupt-style result event
    s_next.evt = s_reg.rdy_prev && !rdy_s;
    case (s_reg.st)
      ST_IDLE:
      begin
        // strobes and select parked high, clock low
        s_next.sclk = 1'b0;
        s_next.rfs_n = 1'b1;
        s_next.tfs_n = 1'b1;
        s_next.rsel = 1'b1;
        s_next.oe = 1'b0;
        if (cmd_valid)
        begin
          s_next.wr = cmd_write;
          s_next.tgt = cmd_target;
          s_next.lsb = cmd_lsb_first;
          s_next.bit_cnt = 3'h0;
          s_next.byte_cnt = 2'h0;
          // caller bytes arriving LSB first are turned round per byte
          s_next.shift = cmd_lsb_first ? ahss_rev_bytes(cmd_wdata) : cmd_wdata;
          if (refused(cmd_write, cmd_target, tied_select))
          begin
            // answered at once, no pin moves
            s_next.rsp_valid = 1'b1;
            s_next.rsp_err = 1'b1;
          end
          else if (!cmd_write && cmd_target == TGT_DATA)
            s_next.st = ST_WAIT_RDY;
          else
            s_next.st = ST_OPEN; // register access ignores ready
        end
      end
      ST_WAIT_RDY:
      begin
        // only a low ready line lets a data byte start
        if (!rdy_s)
          s_next.st = (s_reg.byte_cnt == 2'h0) ? ST_OPEN : ST_LOW;
      end
      ST_OPEN:
      begin
        // select settles together with the frame strobe
        s_next.rsel = select_level(s_reg.wr, s_reg.tgt, tied_select);
        if (s_reg.wr)
        begin
          // receive strobe stays high while transmit goes low, so here transmit is its inverse
          s_next.tfs_n = 1'b0;
          s_next.sdo = s_reg.shift[23];
          s_next.oe = 1'b1;
        end
        else
          s_next.rfs_n = 1'b0;
        s_next.st = ST_LOW;
      end
      ST_LOW:
      begin
        // rising edge: device takes write data, read data already stable
        if (tick)
        begin
          s_next.sclk = 1'b1;
          s_next.st = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (tick)
        begin
          // falling edge; read bit sampled late in the high phase
          s_next.sclk = 1'b0;
          s_next.shift = {s_reg.shift[22:0], s_reg.wr ? 1'b0 : sdi_s};
          s_next.sdo = s_reg.shift[22];
          s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
          s_next.st = ST_LOW;
          if (s_reg.bit_cnt == LAST_BIT)
          begin
            // byte boundary: 24 bits make one operation
            if (s_reg.byte_cnt == LAST_BYTE)
              s_next.st = ST_CLOSE;
            else
            begin
              s_next.byte_cnt = s_reg.byte_cnt + 2'h1;
              if (!s_reg.wr && s_reg.tgt == TGT_DATA)
                s_next.st = ST_WAIT_RDY;
            end
          end
        end
      end
      ST_CLOSE:
      begin
        // one low half after the last fall, then strobes go high
        if (tick)
        begin
          s_next.rfs_n = 1'b1;
          s_next.tfs_n = 1'b1;
          s_next.rsel = 1'b1;
          s_next.oe = 1'b0;
          s_next.sdo = 1'b0;
          s_next.rsp_valid = 1'b1;
          s_next.rsp_err = 1'b0;
          s_next.rsp_data = s_reg.wr ? 24'h000000 :
            (s_reg.lsb ? ahss_rev_bytes(s_reg.shift) : s_reg.shift);
          s_next.st = ST_IDLE;
        end
      end
      default:
        s_next.st = ST_IDLE;
    endcase
  end

  // state register; reset leaves every strobe idle
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.tgt <= TGT_DATA;
      s_reg.rfs_n <= 1'b1;
      s_reg.tfs_n <= 1'b1;
      s_reg.rsel <= 1'b1;
      s_reg.rdy_prev <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // every output straight from the state record
  assign serial_clk = s_reg.sclk;
  assign receive_frame_n = s_reg.rfs_n;
  assign transmit_frame_n = s_reg.tfs_n;
  assign register_select = s_reg.rsel;
  assign serial_data_o = s_reg.sdo;
  assign serial_data_oe = s_reg.oe;
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_error = s_reg.rsp_err;
  assign rsp_data = s_reg.rsp_data;
  assign result_event = s_reg.evt;

  // helper: serial clock rises seen in the current frame
  logic sclk_d;
  logic [4:0] pulse_cnt;
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sclk_d <= 1'b0;
      pulse_cnt <= 5'h00;
    end
    else
    begin
      sclk_d <= s_reg.sclk;
      if (s_reg.rfs_n && s_reg.tfs_n)
        pulse_cnt <= 5'h00;
      else if (s_reg.sclk && !sclk_d)
        pulse_cnt <= pulse_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  // a frame closing on either strobe
  sequence s_frame_close;
    $rose(receive_frame_n) || $rose(transmit_frame_n);
  endsequence
  // a data read starting
  sequence s_data_read_open;
    $fell(receive_frame_n) && s_reg.tgt == TGT_DATA;
  endsequence

  a_tied_write_ctrl: assert property (tied_select && !transmit_frame_n |-> !register_select)
    else $error("tied write not aimed at control register");
  a_tied_read_data: assert property (tied_select && !receive_frame_n |-> register_select)
    else $error("tied read not aimed at data register");
  a_tied_ctrl_refuse: assert property (cmd_valid && cmd_ready && tied_select && !cmd_write
    && cmd_target == TGT_CTRL |=> rsp_valid && rsp_error && receive_frame_n)
    else $error("tied control read not refused");
  a_strobes_exclusive: assert property (!(!receive_frame_n && !transmit_frame_n))
    else $error("both frame strobes low");
  a_ctrl_read_select: assert property ($fell(receive_frame_n) && !tied_select
    && s_reg.tgt == TGT_CTRL |-> !register_select)
    else $error("control read without select low");
  a_ready_gates_read: assert property (s_data_read_open |-> !$past(rdy_s, 2))
    else $error("data read opened with ready high");
  a_msb_first: assert property ($fell(transmit_frame_n) |-> serial_data_o == $past(s_reg.shift[23])
    && serial_data_oe)
    else $error("first write bit is not the msb");
  a_word_pulses: assert property (s_frame_close |-> pulse_cnt == WORD_PULSES)
    else $error("frame closed without 24 clock pulses");
  a_idle_levels: assert property (s_reg.st == ST_IDLE |-> !serial_clk && receive_frame_n
    && transmit_frame_n && register_select && !serial_data_oe)
    else $error("idle pin levels wrong");
  a_clk_low_close: assert property (s_frame_close |-> !serial_clk ##1 !serial_clk)
    else $error("serial clock not low around frame end");

  // a data byte may not start while the synced ready line is high
  a_wait_holds_ready: assert property (s_reg.st == ST_WAIT_RDY && rdy_s
    |=> s_reg.st == ST_WAIT_RDY)
    else $error("data byte started with ready high");
  // select must not move once a read frame is open
  a_select_steady: assert property (!receive_frame_n && !$fell(receive_frame_n)
    |-> $stable(register_select))
    else $error("select moved during a read frame");
  // the shared data line is only driven inside a write frame
  a_oe_in_write: assert property (serial_data_oe
    |-> !transmit_frame_n && receive_frame_n)
    else $error("data line driven outside a write frame");
  // the answer leaves together with the closing strobe
  a_close_answers: assert property (s_frame_close |-> rsp_valid && !rsp_error)
    else $error("frame closed without an answer");
  // the serial clock stays parked while a data byte waits for ready
  a_clk_parked_wait: assert property (s_reg.st == ST_WAIT_RDY |-> !serial_clk)
    else $error("serial clock high while waiting for ready");
endmodule
`default_nettype wire

// File: logic/ahss_pkg.sv
`default_nettype none
package ahss_pkg;
  // master clock and serial clock timing
  localparam int CLK_NS = 40;
  localparam int SCLK_HALF_NS = 160;
  // least time, so round up to whole cycles
  localparam int HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  // word layout
  localparam int WORD_BITS = 24;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] LAST_BYTE = 2'h2;
  localparam logic [4:0] WORD_PULSES = 5'h18;
  // register targets on the device
  typedef enum logic [1:0] {TGT_DATA, TGT_CTRL, TGT_CAL} ahss_target_t;
  // sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_RDY, ST_OPEN, ST_LOW, ST_HIGH, ST_CLOSE}
    ahss_state_t;

  // reverse bit order inside each byte of a word
  function automatic logic [23:0] ahss_rev_bytes(input logic [23:0] w);
    logic [23:0] r;
    r = '0;
    for (int i = 0; i < WORD_BITS; i++)
    begin
      r[i] = w[(i / 8) * 8 + 7 - (i % 8)];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// File: logic/ahss_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ahss_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // first stage feeds only the second stage
  logic [W-1:0] meta_reg;
  // two flops in front of any logic; reset to the idle-high pin level
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire
